// ### core/cbf_crossbar_fabric.sv
// eight-port crossbar packet fabric with ingress/egress queues and output arbiters
// What this block does
// - eight full-duplex ports, non-blocking, ingress at line rate, egress two words per three cycles
// - ingress offers one packet at a time
// - egress takes one packet at a time
// - disjoint port pairs transfer concurrently
// - packets stored only in per-port queues
// - packet moves whole, never interleaved
// - ingress routes by destination table lookup
// - ingress queue holds eight packets
// - egress queue holds eight packets
// - per-port mode, cut-through after reset
// - store-and-forward requests after last byte
// - cut-through requests once destination arrived
// - cut-through keeps buffering while egress busy
// - losers keep packets queued and retry
// - egress keeps packets for retransmission
// - each egress has its own arbiter
// - strict priority, higher level wins
// - round robin per priority per egress
// - fabric logic runs up to 156.25 MHz
// - egress free-buffer thresholds per priority
// - ingress admission thresholds per priority
// - egress sends in arrival order, except retry
`timescale 1ns/1ps
module cbf_crossbar_fabric (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // configuration
    input wire logic [cbf_pkg::NPORT-1:0] forwarding_mode_select_in,
    input wire logic [cbf_pkg::RT_N-1:0][cbf_pkg::PORT_W-1:0] route_tbl_in,
    // ingress streams
    input wire logic [cbf_pkg::NPORT-1:0] ig_valid_in,
    input wire logic [cbf_pkg::NPORT-1:0] ig_sop_in,
    input wire logic [cbf_pkg::NPORT-1:0] ig_eop_in,
    input wire logic [cbf_pkg::NPORT-1:0][cbf_pkg::DATA_W-1:0] ig_data_in,
    input wire logic [cbf_pkg::NPORT-1:0][cbf_pkg::PRIO_W-1:0] ig_prio_in,
    output wire logic [cbf_pkg::NPORT-1:0] ig_refuse_out,
    // egress streams
    output wire logic [cbf_pkg::NPORT-1:0] eg_valid_out,
    output wire logic [cbf_pkg::NPORT-1:0] eg_eop_out,
    output wire logic [cbf_pkg::NPORT-1:0][cbf_pkg::DATA_W-1:0] eg_data_out,
    input wire logic [cbf_pkg::NPORT-1:0] eg_ready_in,
    input wire logic [cbf_pkg::NPORT-1:0] eg_ack_in,
    input wire logic [cbf_pkg::NPORT-1:0] eg_retry_in
);
    import cbf_pkg::*;

    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];
    logic [NPORT-1:0] fsf_r;
    logic [NPORT-1:0] ig_gnt_w;
    wire [NPORT-1:0] ig_req_w;
    wire [NPORT-1:0] ig_vr_w;
    wire [NPORT-1:0] ig_veop_w;
    wire [NPORT-1:0] ig_idle_w;
    wire [NPORT-1:0][PORT_W-1:0] ig_dst_w;
    wire [NPORT-1:0][PORT_W-1:0] ig_vdst_w;
    wire [NPORT-1:0][PRIO_W-1:0] ig_pri_w;
    wire [NPORT-1:0][DATA_W-1:0] ig_rdata_w;
    wire [NPORT-1:0][NPORT-1:0] eg_gnt_w;

    // first index at or after the pointer that is requesting
    function automatic logic [PORT_W:0] rr_pick(input logic [NPORT-1:0] req,
                                               input logic [PORT_W-1:0] ptr);
        logic [PORT_W:0] res;
        logic [PORT_W-1:0] idx;
        res = '0;
        for (int k = NPORT - 1; k >= 0; k--) begin
            idx = ptr + PORT_W'(k);
            if (req[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction : rr_pick

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // mode is taken only while a port's ingress queue is empty
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fsf_r <= FWD_RST;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (ig_idle_w[i]) begin
                    fsf_r[i] <= forwarding_mode_select_in[i];
                end
            end
        end
    end

    // each ingress is granted by at most one egress, so the or is exact
    always_comb begin
        ig_gnt_w = '0;
        for (int e = 0; e < NPORT; e++) begin
            ig_gnt_w = ig_gnt_w | eg_gnt_w[e];
        end
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_ig
        logic [SLOT_W-1:0] h_r, t_r;
        logic [CNT_W-1:0] n_r;
        logic wr_r, busy_r, vr_r, veop_r, ref_r;
        logic [LEN_W-1:0] rp_r;
        logic [PORT_W-1:0] cdst_r, vdst_r;
        logic [NSLOT-1:0] done_r;
        logic [NSLOT-1:0][LEN_W-1:0] len_r;
        logic [NSLOT-1:0][PORT_W-1:0] dst_r;
        logic [NSLOT-1:0][PRIO_W-1:0] pri_r;
        wire sop_w = ig_valid_in[p] & ig_sop_in[p];
        wire admit_w = sop_w & prio_ok(CNT_NSLOT - n_r, ig_prio_in[p]);
        wire cont_w = ig_valid_in[p] & ~ig_sop_in[p] & wr_r;
        wire [LEN_W-1:0] wlen_w = admit_w ? LEN_ZERO : len_r[t_r];
        // words past the slot size are dropped, eop still closes the slot
        wire wacc_w = (admit_w | cont_w) & (wlen_w != LEN_MAX);
        wire close_w = (admit_w | cont_w) & ig_eop_in[p];
        wire [LEN_W-1:0] hlen_w = len_r[h_r];
        wire hdone_w = done_r[h_r];
        wire hold_w = fsf_r[p] ? ~hdone_w : (hlen_w == LEN_ZERO);
        // cut-through stays one word behind so eop is known when read
        wire rd_w = busy_r & (hdone_w ? (rp_r < hlen_w) : (rp_r + LEN_ONE < hlen_w));
        wire last_w = hdone_w & (rp_r + LEN_ONE == hlen_w);
        wire rel_w = rd_w & last_w;
        wire [RT_W-1:0] did_w = ig_data_in[p][RT_W-1:0];

        assign ig_req_w[p] = (n_r != CNT_ZERO) & ~busy_r & ~hold_w;
        assign ig_dst_w[p] = dst_r[h_r];
        assign ig_pri_w[p] = pri_r[h_r];
        assign ig_vr_w[p] = vr_r;
        assign ig_veop_w[p] = veop_r;
        assign ig_vdst_w[p] = vdst_r;
        assign ig_idle_w[p] = (n_r == CNT_ZERO) & ~busy_r & ~vr_r;
        assign ig_refuse_out[p] = ref_r;

        cbf_pkt_mem u_mem (
            .clk_in(sys_clk_in),
            .wr_en_in(wacc_w),
            .wr_addr_in({t_r, wlen_w[WORD_W-1:0]}),
            .wr_data_in(ig_data_in[p]),
            .rd_en_in(rd_w),
            .rd_addr_in({h_r, rp_r[WORD_W-1:0]}),
            .rd_data_out(ig_rdata_w[p])
        );

        always_ff @(posedge sys_clk_in or negedge rst_n) begin
            if (!rst_n) begin
                h_r <= '0;
                t_r <= '0;
                n_r <= CNT_ZERO;
                wr_r <= 1'b0;
                busy_r <= 1'b0;
                vr_r <= 1'b0;
                veop_r <= 1'b0;
                ref_r <= 1'b0;
                rp_r <= LEN_ZERO;
                cdst_r <= '0;
                vdst_r <= '0;
                done_r <= '0;
                len_r <= '0;
                dst_r <= '0;
                pri_r <= '0;
            end else begin
                ref_r <= sop_w & ~admit_w;
                n_r <= n_r + CNT_W'(admit_w) - CNT_W'(rel_w);
                if (admit_w) begin
                    dst_r[t_r] <= route_tbl_in[did_w];
                    pri_r[t_r] <= ig_prio_in[p];
                    done_r[t_r] <= 1'b0;
                    wr_r <= 1'b1;
                end
                if (wacc_w) begin
                    len_r[t_r] <= wlen_w + LEN_ONE;
                end
                if (close_w) begin
                    done_r[t_r] <= 1'b1;
                    wr_r <= 1'b0;
                    t_r <= t_r + SLOT_ONE;
                end
                if (ig_gnt_w[p]) begin
                    busy_r <= 1'b1;
                    rp_r <= LEN_ZERO;
                    cdst_r <= dst_r[h_r];
                end
                if (rd_w) begin
                    rp_r <= rp_r + LEN_ONE;
                end
                if (rel_w) begin
                    busy_r <= 1'b0;
                    h_r <= h_r + SLOT_ONE;
                end
                // one register stage across the crossbar keeps paths short
                vr_r <= rd_w;
                veop_r <= last_w;
                vdst_r <= cdst_r;
            end
        end
    end

    for (genvar e = 0; e < NPORT; e++) begin : g_eg
        logic busy_r, pend_r, peop_r, rtry_r;
        logic [PORT_W-1:0] src_r;
        logic [SLOT_W-1:0] t_r, h_r, sp_r;
        logic [CNT_W-1:0] ne_r, ns_r;
        logic [LEN_W-1:0] wl_r, ew_r;
        logic [NSLOT-1:0] done_r;
        logic [NSLOT-1:0][LEN_W-1:0] len_r;
        logic [NPRIO-1:0][PORT_W-1:0] rr_r;
        logic [NPRIO-1:0][NPORT-1:0] rq_w;
        logic [PRIO_W-1:0] lvl_w;
        logic any_w;
        logic [PORT_W:0] pick_w;
        logic [DATA_W-1:0] rdata_w;
        logic sk_rdy_w, sk_empty_w;
        logic [BUF_W-1:0] sk_out_w;
        wire sk_valid_w;
        wire [CNT_W-1:0] free_w = CNT_NSLOT - ne_r;

        always_comb begin
            rq_w = '0;
            lvl_w = '0;
            any_w = 1'b0;
            for (int pl = 0; pl < NPRIO; pl++) begin
                for (int i = 0; i < NPORT; i++) begin
                    rq_w[pl][i] = ig_req_w[i] & (ig_dst_w[i] == PORT_W'(e)) &
                                  (ig_pri_w[i] == PRIO_W'(pl)) &
                                  prio_ok(free_w, PRIO_W'(pl));
                end
                if (|rq_w[pl]) begin
                    lvl_w = PRIO_W'(pl);
                    any_w = 1'b1;
                end
            end
            pick_w = rr_pick(rq_w[lvl_w], rr_r[lvl_w]);
        end

        wire gnt_w = any_w & ~busy_r;
        assign eg_gnt_w[e] = gnt_w ? (NPORT'(1) << pick_w[PORT_W-1:0]) : '0;
        wire wen_w = busy_r & ig_vr_w[src_r] & (ig_vdst_w[src_r] == PORT_W'(e));
        wire weop_w = wen_w & ig_veop_w[src_r];
        wire slast_w = (ew_r + LEN_ONE == len_r[sp_r]);
        wire ack_w = eg_ack_in[e] & (ns_r != CNT_ZERO);
        // a rewind waits for a packet boundary so no packet goes out cut short
        wire appl_w = rtry_r & (ew_r == LEN_ZERO) & ~ack_w;
        wire room_w = pend_r ? sk_empty_w : sk_rdy_w;
        wire iss_w = (ns_r != ne_r) & done_r[sp_r] & ~(rtry_r & (ew_r == LEN_ZERO)) &
                     room_w;

        assign eg_valid_out[e] = sk_valid_w;
        assign eg_eop_out[e] = sk_out_w[BUF_W-1];
        assign eg_data_out[e] = sk_out_w[DATA_W-1:0];

        cbf_pkt_mem u_mem (
            .clk_in(sys_clk_in),
            .wr_en_in(wen_w),
            .wr_addr_in({t_r, wl_r[WORD_W-1:0]}),
            .wr_data_in(ig_rdata_w[src_r]),
            .rd_en_in(iss_w),
            .rd_addr_in({sp_r, ew_r[WORD_W-1:0]}),
            .rd_data_out(rdata_w)
        );

        cbf_skid2 u_buf (
            .clk_in(sys_clk_in),
            .rst_n_in(rst_n),
            .in_valid_in(pend_r),
            .in_data_in({peop_r, rdata_w}),
            .in_ready_out(sk_rdy_w),
            .empty_out(sk_empty_w),
            .out_valid_out(sk_valid_w),
            .out_data_out(sk_out_w),
            .out_ready_in(eg_ready_in[e])
        );

        always_ff @(posedge sys_clk_in or negedge rst_n) begin
            if (!rst_n) begin
                busy_r <= 1'b0;
                pend_r <= 1'b0;
                peop_r <= 1'b0;
                rtry_r <= 1'b0;
                src_r <= '0;
                t_r <= '0;
                h_r <= '0;
                sp_r <= '0;
                ne_r <= CNT_ZERO;
                ns_r <= CNT_ZERO;
                wl_r <= LEN_ZERO;
                ew_r <= LEN_ZERO;
                done_r <= '0;
                len_r <= '0;
                rr_r <= '0;
            end else begin
                pend_r <= iss_w;
                peop_r <= slast_w;
                rtry_r <= eg_retry_in[e] | (rtry_r & ~appl_w);
                ne_r <= ne_r + CNT_W'(gnt_w) - CNT_W'(ack_w);
                if (gnt_w) begin
                    busy_r <= 1'b1;
                    src_r <= pick_w[PORT_W-1:0];
                    done_r[t_r] <= 1'b0;
                    wl_r <= LEN_ZERO;
                    rr_r[lvl_w] <= pick_w[PORT_W-1:0] + PORT_ONE;
                end
                if (wen_w) begin
                    wl_r <= wl_r + LEN_ONE;
                end
                if (weop_w) begin
                    len_r[t_r] <= wl_r + LEN_ONE;
                    done_r[t_r] <= 1'b1;
                    t_r <= t_r + SLOT_ONE;
                    busy_r <= 1'b0;
                end
                if (ack_w) begin
                    h_r <= h_r + SLOT_ONE;
                end
                if (appl_w) begin
                    sp_r <= h_r;
                    ns_r <= CNT_ZERO;
                end else begin
                    ns_r <= ns_r + CNT_W'(iss_w & slast_w) - CNT_W'(ack_w);
                    if (iss_w & slast_w) begin
                        sp_r <= sp_r + SLOT_ONE;
                    end
                end
                if (iss_w) begin
                    ew_r <= slast_w ? LEN_ZERO : ew_r + LEN_ONE;
                end
            end
        end
    end
endmodule : cbf_crossbar_fabric

// ### core/cbf_pkg.sv
// shared constants, widths and helpers for the crossbar packet fabric
package cbf_pkg;
    localparam int NPORT = 8;
    localparam int PORT_W = 3;
    localparam int DATA_W = 32;
    localparam int NSLOT = 8;
    localparam int SLOT_W = 3;
    localparam int WORD_W = 4;
    localparam int LEN_W = 5;
    localparam int ADDR_W = 7;
    localparam int MEM_DEPTH = 128;
    localparam int NPRIO = 4;
    localparam int PRIO_W = 2;
    localparam int RT_N = 16;
    localparam int RT_W = 4;
    localparam int CNT_W = 4;
    localparam int BUF_W = 33;
    localparam int BUF_DEPTH = 2;
    // fabric clock figures in kHz; sys clock must stay at or below the maximum
    localparam int FABRIC_MAX_KHZ = 156250;
    localparam int CLK_KHZ = 50000;
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_NSLOT = 4'h8;
    localparam logic [LEN_W-1:0] LEN_ZERO = 5'h00;
    localparam logic [LEN_W-1:0] LEN_ONE = 5'h01;
    localparam logic [LEN_W-1:0] LEN_MAX = 5'h10;
    localparam logic [SLOT_W-1:0] SLOT_ONE = 3'h1;
    localparam logic [PORT_W-1:0] PORT_ONE = 3'h1;
    localparam logic [NPORT-1:0] FWD_RST = 8'h00;

    // free buffers needed: priority 3 needs one, priority 0 needs four
    function automatic logic prio_ok(input logic [CNT_W-1:0] free, input logic [PRIO_W-1:0] pr);
        return free >= (CNT_W'(NPRIO) - CNT_W'(pr));
    endfunction : prio_ok
endpackage : cbf_pkg

// ### core/cbf_pkt_mem.sv
// packet word store for one port queue, registered read data
`timescale 1ns/1ps
module cbf_pkt_mem (
    // clock
    input wire logic clk_in,
    // write side
    input wire logic wr_en_in,
    input wire logic [cbf_pkg::ADDR_W-1:0] wr_addr_in,
    input wire logic [cbf_pkg::DATA_W-1:0] wr_data_in,
    // read side
    input wire logic rd_en_in,
    input wire logic [cbf_pkg::ADDR_W-1:0] rd_addr_in,
    output logic [cbf_pkg::DATA_W-1:0] rd_data_out
);
    import cbf_pkg::*;
    logic [DATA_W-1:0] mem_r [MEM_DEPTH];

    // no reset on the array keeps it a plain ram
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end
endmodule : cbf_pkt_mem

// ### core/cbf_skid2.sv
// two-entry buffer between egress queue and link, valid/ready both sides
`timescale 1ns/1ps
module cbf_skid2 (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [cbf_pkg::BUF_W-1:0] in_data_in,
    output wire logic in_ready_out,
    output wire logic empty_out,
    // drain side
    output wire logic out_valid_out,
    output wire logic [cbf_pkg::BUF_W-1:0] out_data_out,
    input wire logic out_ready_in
);
    import cbf_pkg::*;
    logic [BUF_W-1:0] mem_r [BUF_DEPTH];
    logic wp_r, rp_r;
    logic [1:0] cnt_r;
    wire push_w = in_valid_in & in_ready_out;
    wire pop_w = out_valid_out & out_ready_in;

    assign in_ready_out = (cnt_r != 2'h2);
    assign empty_out = (cnt_r == 2'h0);
    assign out_valid_out = ~empty_out;
    assign out_data_out = mem_r[rp_r];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (push_w) begin
                mem_r[wp_r] <= in_data_in;
                wp_r <= ~wp_r;
            end
            if (pop_w) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + 2'(push_w) - 2'(pop_w);
        end
    end
endmodule : cbf_skid2

// ### testbench/cbf_crossbar_fabric_asserts.sv
// concurrent checks on the crossbar fabric ports
`timescale 1ns/1ps
module cbf_crossbar_fabric_asserts (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // ingress side
    input wire logic [cbf_pkg::NPORT-1:0] ig_valid_in,
    input wire logic [cbf_pkg::NPORT-1:0] ig_sop_in,
    input wire logic [cbf_pkg::NPORT-1:0] ig_eop_in,
    input wire logic [cbf_pkg::NPORT-1:0][cbf_pkg::PRIO_W-1:0] ig_prio_in,
    input wire logic [cbf_pkg::NPORT-1:0] ig_refuse_out,
    // egress side
    input wire logic [cbf_pkg::NPORT-1:0] eg_valid_out,
    input wire logic [cbf_pkg::NPORT-1:0] eg_eop_out,
    input wire logic [cbf_pkg::NPORT-1:0][cbf_pkg::DATA_W-1:0] eg_data_out,
    input wire logic [cbf_pkg::NPORT-1:0] eg_ready_in
);
    import cbf_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [2:0] since_eop_r;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            since_eop_r <= 3'h0;
        end else if (since_eop_r != 3'h0 && since_eop_r != 3'h7) begin
            since_eop_r <= since_eop_r + 3'h1;
        end else if (since_eop_r == 3'h0 && (ig_valid_in & ig_eop_in) != '0) begin
            since_eop_r <= 3'h1;
        end
    end
    reset_quiet_a: assert property (disable iff (1'b0) !rst_b_in |=>
        eg_valid_out == '0 && ig_refuse_out == '0) else $error("output active in reset");
    egress_late_a: assert property (eg_valid_out != '0 |-> since_eop_r >= 3'h3)
        else $error("egress word before any whole packet");
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        // sop count bounds the slots held, so it is a safe lower limit for refusals
        logic [3:0] sop_cnt_r;
        logic [4:0] wc_r;
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sop_cnt_r <= 4'h0;
                wc_r <= 5'h00;
            end else begin
                if (ig_valid_in[p] && ig_sop_in[p] && sop_cnt_r != 4'hF) begin
                    sop_cnt_r <= sop_cnt_r + 4'h1;
                end
                if (eg_valid_out[p] && eg_ready_in[p]) begin
                    wc_r <= eg_eop_out[p] ? 5'h00 : wc_r + 5'h01;
                end
            end
        end
        refuse_cause_a: assert property (ig_refuse_out[p] |->
            $past(ig_valid_in[p] && ig_sop_in[p])) else $error("refusal without a packet start");
        refuse_level_a: assert property (ig_refuse_out[p] |->
            $past(sop_cnt_r) >= 4'h5 + {2'h0, $past(ig_prio_in[p])})
            else $error("refused with room");
        egress_hold_a: assert property (eg_valid_out[p] && !eg_ready_in[p] |=>
            eg_valid_out[p]) else $error("egress word withdrawn while stalled");
        egress_data_a: assert property (eg_valid_out[p] && !eg_ready_in[p] |=>
            $stable(eg_data_out[p])) else $error("egress data changed while stalled");
        egress_eop_a: assert property (eg_valid_out[p] && !eg_ready_in[p] |=>
            $stable(eg_eop_out[p])) else $error("egress end flag changed while stalled");
        egress_len_a: assert property (eg_valid_out[p] && eg_ready_in[p] && wc_r == 5'h0F
            |-> eg_eop_out[p]) else $error("egress packet longer than sixteen words");
    end
endmodule : cbf_crossbar_fabric_asserts

bind cbf_crossbar_fabric cbf_crossbar_fabric_asserts u_cbf_crossbar_fabric_asserts (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ig_valid_in(ig_valid_in),
    .ig_sop_in(ig_sop_in), .ig_eop_in(ig_eop_in), .ig_prio_in(ig_prio_in),
    .ig_refuse_out(ig_refuse_out), .eg_valid_out(eg_valid_out), .eg_eop_out(eg_eop_out),
    .eg_data_out(eg_data_out), .eg_ready_in(eg_ready_in));

// ### testbench/cbf_link_model.sv
// link-side model: egress sink with stall, ack and retry controls
`timescale 1ns/1ps
module cbf_link_model (
    // clock
    input wire logic clk_in,
    // egress stream seen from the link
    input wire logic [cbf_pkg::NPORT-1:0] valid_in,
    input wire logic [cbf_pkg::NPORT-1:0] eop_in,
    // scenario controls
    input wire logic [cbf_pkg::NPORT-1:0] stall_in,
    input wire logic [cbf_pkg::NPORT-1:0] hold_in,
    input wire logic [cbf_pkg::NPORT-1:0] ack_req_in,
    input wire logic [cbf_pkg::NPORT-1:0] retry_req_in,
    // answers to the fabric
    output wire logic [cbf_pkg::NPORT-1:0] ready_out,
    output wire logic [cbf_pkg::NPORT-1:0] ack_out,
    output wire logic [cbf_pkg::NPORT-1:0] retry_out
);
    import cbf_pkg::*;
    logic [NPORT-1:0] ack_r = '0;
    // ack each whole packet a cycle later, unless held back to keep slots busy
    always @(posedge clk_in) begin
        ack_r <= valid_in & eop_in & ready_out & ~hold_in;
    end
    assign ready_out = ~stall_in;
    assign ack_out = ack_r | ack_req_in;
    assign retry_out = retry_req_in;
endmodule : cbf_link_model

// ### testbench/tb_top.sv
// self-checking bench for the crossbar packet fabric
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, x); end end
module tb_top;
    import cbf_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [NPORT-1:0] fwd_mode = '0, ig_v = '0, ig_s = '0, ig_e = '0;
    logic [NPORT-1:0] stall = '0, hold = '0, ackr = '0, rtyr = '0;
    logic [NPORT-1:0][DATA_W-1:0] ig_d = '0;
    logic [NPORT-1:0][PRIO_W-1:0] ig_p = '0;
    logic [RT_N-1:0][PORT_W-1:0] route;
    wire logic [NPORT-1:0] refuse, eg_v, eg_e, rdy, ack, rty;
    wire logic [NPORT-1:0][DATA_W-1:0] eg_d;
    logic [32:0] cap_q[NPORT][$];
    int miscompares = 0, check_count = 0, cyc = 0, ref_n = 0;

    cbf_crossbar_fabric u_cbf_crossbar_fabric (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .forwarding_mode_select_in(fwd_mode), .route_tbl_in(route), .ig_valid_in(ig_v),
        .ig_sop_in(ig_s), .ig_eop_in(ig_e), .ig_data_in(ig_d), .ig_prio_in(ig_p),
        .ig_refuse_out(refuse), .eg_valid_out(eg_v), .eg_eop_out(eg_e), .eg_data_out(eg_d),
        .eg_ready_in(rdy), .eg_ack_in(ack), .eg_retry_in(rty));
    cbf_link_model u_cbf_link_model (.clk_in(sys_clk_in), .valid_in(eg_v), .eop_in(eg_e),
        .stall_in(stall), .hold_in(hold), .ack_req_in(ackr), .retry_req_in(rtyr),
        .ready_out(rdy), .ack_out(ack), .retry_out(rty));

    always #10 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        ref_n <= ref_n + $countones(refuse);
        for (int i = 0; i < NPORT; i++) begin
            if (eg_v[i] === 1'b1 && rdy[i] === 1'b1) cap_q[i].push_back({eg_e[i], eg_d[i]});
        end
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    function automatic logic [31:0] w(input int p, input int id, input int k, input int d);
        return {4'hC, 4'(p), 8'(id), 8'(k), 4'h0, 4'(d)};
    endfunction : w
    task automatic send(input int p, input int pr, input int d, input int id, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge sys_clk_in);
            ig_v[p] = 1'b1;
            ig_s[p] = (k == 0);
            ig_e[p] = (k == n - 1);
            ig_p[p] = 2'(pr);
            ig_d[p] = w(p, id, k, d);
        end
        @(negedge sys_clk_in);
        ig_v[p] = 1'b0;
        ig_s[p] = 1'b0;
        ig_e[p] = 1'b0;
    endtask : send
    task automatic chk_pkt(input int e, input int p, input int id, input int d, input int n);
        logic [32:0] got;
        int t;
        t = 0;
        while (cap_q[e].size() < n && t < 800) begin
            @(posedge sys_clk_in);
            t++;
        end
        for (int k = 0; k < n; k++) begin
            got = cap_q[e].size() > 0 ? cap_q[e].pop_front() : 33'h0;
            `CHK(got, {k == n - 1, w(p, id, k, d)})
        end
    endtask : chk_pkt
    task automatic t_route();
        for (int d = 0; d < 16; d++) send(0, 3, d, d, 2);
        for (int d = 0; d < 16; d++) chk_pkt(7 - d % 8, 0, d, d, 2);
        $display("test route done");
    endtask : t_route
    task automatic t_conc();
        int t0;
        t0 = cyc;
        for (int i = 0; i < NPORT; i++) begin
            fork
                automatic int q = i;
                send(q, 2, q, 40 + q, 4);
            join_none
        end
        wait fork;
        for (int i = 0; i < NPORT; i++) chk_pkt(7 - i, i, 40 + i, i, 4);
        `CHK(cyc - t0 <= 24, 1'b1)
        $display("test concurrent done");
    endtask : t_conc
    task automatic t_prio();
        fork
            send(1, 1, 15, 50, 3);
            send(2, 3, 15, 51, 3);
            send(3, 2, 15, 52, 3);
        join
        chk_pkt(0, 2, 51, 15, 3);
        chk_pkt(0, 3, 52, 15, 3);
        chk_pkt(0, 1, 50, 15, 3);
        $display("test priority done");
    endtask : t_prio
    task automatic t_rr();
        // pointer for this level sits just past port 3 after the previous test
        fork
            send(1, 2, 15, 53, 2);
            send(5, 2, 15, 54, 2);
            send(6, 2, 15, 55, 2);
        join
        chk_pkt(0, 5, 54, 15, 2);
        chk_pkt(0, 6, 55, 15, 2);
        chk_pkt(0, 1, 53, 15, 2);
        $display("test round robin done");
    endtask : t_rr
    task automatic t_mode();
        int t0;
        int lat[2];
        for (int m = 0; m < 2; m++) begin
            @(negedge sys_clk_in);
            fwd_mode[2] = m[0];
            send(2, 3, 13, 60 + m, 16);
            t0 = cyc;
            while (cap_q[2].size() == 0 && cyc - t0 < 200) @(posedge sys_clk_in);
            lat[m] = cyc - t0;
            chk_pkt(2, 2, 60 + m, 13, 16);
        end
        `CHK(lat[0] < 12, 1'b1)
        `CHK(lat[1] >= 16, 1'b1)
        @(negedge sys_clk_in);
        fwd_mode[2] = 1'b0;
        $display("test mode done");
    endtask : t_mode
    task automatic t_fill();
        logic [4:0] rf;
        int r0;
        rf = 5'h11;
        @(negedge sys_clk_in);
        stall[0] = 1'b1;
        hold[0] = 1'b1;
        for (int j = 0; j < 8; j++) send(4, 3, 7, 80 + j, 2);
        repeat (40) @(negedge sys_clk_in);
        for (int j = 0; j < 5; j++) send(4, 3, 7, 88 + j, 2);
        for (int j = 0; j < 5; j++) begin
            r0 = ref_n;
            send(4, j == 4 ? 3 : j, 7, 93 + j, 2);
            repeat (2) @(negedge sys_clk_in);
            `CHK(ref_n - r0, rf[j])
        end
        stall[0] = 1'b0;
        for (int j = 0; j < 8; j++) chk_pkt(0, 4, 80 + j, 7, 2);
        repeat (30) @(negedge sys_clk_in);
        `CHK(cap_q[0].size(), 0)
        rtyr[0] = 1'b1;
        @(negedge sys_clk_in);
        rtyr[0] = 1'b0;
        for (int j = 0; j < 8; j++) chk_pkt(0, 4, 80 + j, 7, 2);
        @(negedge sys_clk_in);
        hold[0] = 1'b0;
        for (int j = 0; j < 8; j++) begin
            @(negedge sys_clk_in);
            ackr[0] = 1'b1;
            @(negedge sys_clk_in);
            ackr[0] = 1'b0;
        end
        for (int j = 0; j < 8; j++) chk_pkt(0, 4, j < 5 ? 88 + j : 89 + j, 7, 2);
        $display("test fill done");
    endtask : t_fill
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    initial begin
        for (int k = 0; k < RT_N; k++) route[k] = PORT_W'(15 - k);
        repeat (20) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        t_route();
        t_conc();
        t_prio();
        t_rr();
        t_mode();
        t_fill();
        complete_run();
    end
endmodule : tb_top
